// ===== rtl/svm_pkg.sv
package svm_pkg;
  localparam logic [7:0]  OFS_CTRL1   = 8'h00;
  localparam logic [7:0]  OFS_CTRL2   = 8'h04;
  localparam logic [7:0]  OFS_STAT1   = 8'h08;
  localparam logic [7:0]  OFS_STAT2   = 8'h0C;
  localparam logic [7:0]  OFS_IRQSTAT = 8'h10;
  localparam logic [7:0]  OFS_IRQMASK = 8'h14;
  localparam logic [7:0]  OFS_SEC     = 8'h18;
  localparam int unsigned STAT_ABOVE  = 0;
  localparam int unsigned STAT_DET    = 1;
  localparam logic [31:0] CTRL1_WMASK = 32'h0001_FF1F;
  localparam logic [31:0] CTRL2_WMASK = 32'h0001_FF07;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [1:0]  MASK_RST    = 2'h0;
  localparam logic [1:0]  SEC_RST     = 2'h0;
  localparam logic        LEVEL_RST   = 1'b1;
  localparam logic [1:0]  EDGE_FALL   = 2'h0;
  localparam logic [1:0]  EDGE_RISE   = 2'h1;
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned RESTART_NS  = 100000;
  localparam int unsigned RESTART_CYC = (RESTART_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RESTART_CW  = $clog2(RESTART_CYC + 1);
  localparam int unsigned DIV_W       = 4;

  typedef struct packed {
    logic [14:0] rsvd;
    logic        restartAfterFall;
    logic [1:0]  divSel;
    logic        filterEn;
    logic [1:0]  edgeSel;
    logic        nmiSel;
    logic        resetAct;
    logic        enable;
    logic [2:0]  pad;
    logic [4:0]  level;
  } ch_ctrl_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } chan_evt_t;

  typedef enum logic [1:0] {RUN, HOLD, DELAY} restart_state_t;

  function automatic logic edgeHit(input logic [1:0] sel, input chan_evt_t e);
    case (sel)
      EDGE_FALL: edgeHit = e.fall;
      EDGE_RISE: edgeHit = e.rise;
      default:   edgeHit = e.rise | e.fall;
    endcase
  endfunction

  function automatic logic [DIV_W-1:0] divLast(input logic [1:0] sel);
    divLast = DIV_W'((2 << sel) - 1);
  endfunction
endpackage

// ===== rtl/svm_filter.sv
`timescale 1ns/1ns
module svm_filter (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          reset,
  // control
  input  wire logic          sampleTick,
  input  wire logic          filterEn,
  // comparator
  input  wire logic          cmpAbove,
  // accepted level and crossings
  output svm_pkg::chan_evt_t evt
);
  import svm_pkg::*;

  logic sample_q;
  logic level_q;
  logic levelPrev_q;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sample_q <= LEVEL_RST;
    end else if (sampleTick) begin
      sample_q <= cmpAbove;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      level_q <= LEVEL_RST;
    end else if (!filterEn) begin
      level_q <= cmpAbove;
    end else if (sampleTick && cmpAbove == sample_q) begin
      level_q <= cmpAbove;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      levelPrev_q <= LEVEL_RST;
    end else begin
      levelPrev_q <= level_q;
    end
  end

  // one driver for the whole struct: level, rise, fall
  assign evt = {level_q, level_q & ~levelPrev_q, ~level_q & levelPrev_q};

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_filter_bypass;
    !filterEn |=> level_q == $past(cmpAbove);
  endproperty
  a_filter_bypass: assert property (p_filter_bypass)
    else $error("bypassed level does not follow comparator");

  property p_filter_hold;
    filterEn && !(sampleTick && cmpAbove == sample_q) |=> $stable(level_q);
  endproperty
  a_filter_hold: assert property (p_filter_hold)
    else $error("filtered level changed without two matching samples");
endmodule

// ===== rtl/svm_restart.sv
`timescale 1ns/1ns
module svm_restart (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // channel state
  input  wire logic act,
  input  wire logic afterFall,
  input  wire logic above,
  input  wire logic fall,
  // reset request
  output logic      vmReset
);
  import svm_pkg::*;

  localparam logic [RESTART_CW-1:0] CNT_LAST = RESTART_CW'(RESTART_CYC - 1);

  restart_state_t          state_q;
  logic [RESTART_CW-1:0]   cnt_q;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= RUN;
    end else begin
      case (state_q)
        RUN: begin
          if (act && afterFall && fall) begin
            state_q <= DELAY;
          end else if (act && !afterFall && !above) begin
            state_q <= HOLD;
          end
        end
        HOLD: begin
          if (!act) begin
            state_q <= RUN;
          end else if (above) begin
            state_q <= DELAY;
          end
        end
        DELAY: begin
          if (!act) begin
            state_q <= RUN;
          end else if (!afterFall && !above) begin
            state_q <= HOLD;
          end else if (cnt_q == CNT_LAST) begin
            state_q <= RUN;
          end
        end
        default: state_q <= RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (state_q != DELAY) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign vmReset = (state_q != RUN);

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_below_holds;
    act && !afterFall && !above |=> vmReset;
  endproperty
  a_below_holds: assert property (p_below_holds)
    else $error("reset not held while supply below threshold");

  sequence s_delay_done;
    state_q == DELAY && cnt_q == CNT_LAST && act && (afterFall || above);
  endsequence

  property p_release_time;
    s_delay_done |-> vmReset ##1 !vmReset;
  endproperty
  a_release_time: assert property (p_release_time)
    else $error("restart delay did not end on its last count");
endmodule

// ===== rtl/supply_voltage_monitor_logic.sv
`timescale 1ns/1ns
module supply_voltage_monitor_logic (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        hnonsec,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // low-speed oscillator and comparators
  input  wire logic        lowSpeedOsc,
  input  wire logic        cmpAbove1,
  input  wire logic        cmpAbove2,
  output logic [4:0]       levelSelectCh1,
  output logic [2:0]       levelSelectCh2,
  output logic             cmpEnable1,
  output logic             cmpEnable2,
  // resets, interrupts and events
  output logic             vm1Reset,
  output logic             vm2Reset,
  output logic             nmiReq,
  output logic             maskIrq1,
  output logic             maskIrq2,
  output logic             event1,
  output logic             event2,
  output logic             irq
);
  import svm_pkg::*;

  // bus data phase
  logic        dphValid_q;
  logic        dphWrite_q;
  logic        dphNonsec_q;
  logic [7:0]  dphAddr_q;
  logic        hreadyout_q;
  logic [31:0] hrdata_q;
  logic        accept;
  logic        wrFire;
  logic        rdFire;
  logic [31:0] rdData;

  // configuration and flags
  ch_ctrl_t    ctrl_q [2];
  logic [1:0]  det_q;
  logic [1:0]  irqStat_q;
  logic [1:0]  irqMask_q;
  logic [1:0]  secAttr_q;
  logic        irq_q;

  // sampling
  logic        oscPrev_q;
  logic        oscRise;
  logic [DIV_W-1:0] divCnt_q [2];
  logic [1:0]  tick;

  // channel results
  chan_evt_t   evt [2];
  logic [1:0]  crossing;
  logic [1:0]  irqHit;
  logic [1:0]  chReset;
  logic [1:0]  vmReset_q;
  logic [1:0]  maskIrq_q;
  logic [1:0]  event_q;
  logic        nmiReq_q;

  function automatic logic regAllowed(
    input logic [7:0] addr,
    input logic       nonsec,
    input logic [1:0] sec
  );
    logic ch1Reg;
    logic ch2Reg;
    ch1Reg = (addr == OFS_CTRL1) || (addr == OFS_STAT1);
    ch2Reg = (addr == OFS_CTRL2) || (addr == OFS_STAT2);
    regAllowed = !(nonsec && ((sec[0] && ch1Reg) || (sec[1] && ch2Reg)));
  endfunction

  // address phase capture
  assign accept = hsel && hready && htrans[1];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dphValid_q  <= 1'b0;
      dphWrite_q  <= 1'b0;
      dphNonsec_q <= 1'b0;
      dphAddr_q   <= 8'h00;
    end else if (hready) begin
      dphValid_q  <= accept;
      dphWrite_q  <= hwrite;
      dphNonsec_q <= hnonsec;
      dphAddr_q   <= haddr[7:0];
    end
  end

  // reads take one wait state, writes none
  assign rdFire = dphValid_q && !dphWrite_q && !hreadyout_q;
  assign wrFire = dphValid_q && dphWrite_q;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hreadyout_q <= 1'b1;
    end else if (accept && !hwrite) begin
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  always_comb begin
    rdData = 32'h0000_0000;
    case (dphAddr_q)
      OFS_CTRL1:   rdData = ctrl_q[0];
      OFS_CTRL2:   rdData = ctrl_q[1];
      OFS_STAT1:   rdData = {30'h0, det_q[0], evt[0].level};
      OFS_STAT2:   rdData = {30'h0, det_q[1], evt[1].level};
      OFS_IRQSTAT: rdData = {30'h0, irqStat_q};
      OFS_IRQMASK: rdData = {30'h0, irqMask_q};
      OFS_SEC:     rdData = {30'h0, secAttr_q};
      default:     rdData = 32'h0000_0000;
    endcase
    if (!regAllowed(dphAddr_q, dphNonsec_q, secAttr_q)) begin
      rdData = 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rdFire) begin
      hrdata_q <= rdData;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = 1'b0;

  // security attribute, writable from secure accesses only
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      secAttr_q <= SEC_RST;
    end else if (wrFire && !dphNonsec_q && dphAddr_q == OFS_SEC) begin
      secAttr_q <= hwdata[1:0];
    end
  end

  // interrupt mask
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irqMask_q <= MASK_RST;
    end else if (wrFire && dphAddr_q == OFS_IRQMASK) begin
      irqMask_q <= hwdata[1:0];
    end
  end

  // sticky interrupt status, cleared by read, set wins
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irqStat_q <= 2'h0;
    end else if (rdFire && dphAddr_q == OFS_IRQSTAT) begin
      irqStat_q <= crossing;
    end else begin
      irqStat_q <= irqStat_q | crossing;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irqStat_q & irqMask_q);
    end
  end

  // oscillator edge for the sample dividers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      oscPrev_q <= 1'b0;
    end else begin
      oscPrev_q <= lowSpeedOsc;
    end
  end

  assign oscRise = lowSpeedOsc && !oscPrev_q;

  for (genvar i = 0; i < 2; i++) begin : g_ch
    localparam logic [7:0]  CTRL_OFS = (i == 0) ? OFS_CTRL1 : OFS_CTRL2;
    localparam logic [7:0]  STAT_OFS = (i == 0) ? OFS_STAT1 : OFS_STAT2;
    localparam logic [31:0] WMASK    = (i == 0) ? CTRL1_WMASK : CTRL2_WMASK;

    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        ctrl_q[i] <= ch_ctrl_t'(CTRL_RST);
      end else if (wrFire && dphAddr_q == CTRL_OFS
                   && regAllowed(dphAddr_q, dphNonsec_q, secAttr_q)) begin
        ctrl_q[i] <= ch_ctrl_t'(hwdata & WMASK);
      end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        divCnt_q[i] <= '0;
      end else if (oscRise) begin
        if (divCnt_q[i] >= divLast(ctrl_q[i].divSel)) begin
          divCnt_q[i] <= '0;
        end else begin
          divCnt_q[i] <= divCnt_q[i] + 1'b1;
        end
      end
    end

    assign tick[i] = oscRise && divCnt_q[i] >= divLast(ctrl_q[i].divSel);

    svm_filter u_filter (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .sampleTick (tick[i]),
      .filterEn   (ctrl_q[i].filterEn),
      .cmpAbove   ((i == 0) ? cmpAbove1 : cmpAbove2),
      .evt        (evt[i])
    );

    // both directions count as a crossing
    assign crossing[i] = ctrl_q[i].enable && (evt[i].rise || evt[i].fall);
    assign irqHit[i]   = ctrl_q[i].enable && !ctrl_q[i].resetAct
                         && edgeHit(ctrl_q[i].edgeSel, evt[i]);

    svm_restart u_restart (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .act       (ctrl_q[i].enable && ctrl_q[i].resetAct),
      .afterFall (ctrl_q[i].restartAfterFall),
      .above     (evt[i].level),
      .fall      (evt[i].fall),
      .vmReset   (chReset[i])
    );

    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        vmReset_q[i] <= 1'b0;
      end else begin
        vmReset_q[i] <= chReset[i];
      end
    end

    // detection flag: write zero to clear, set wins
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        det_q[i] <= 1'b0;
      end else if (crossing[i]) begin
        det_q[i] <= 1'b1;
      end else if (wrFire && dphAddr_q == STAT_OFS && !hwdata[STAT_DET]
                   && regAllowed(dphAddr_q, dphNonsec_q, secAttr_q)) begin
        det_q[i] <= 1'b0;
      end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        event_q[i]   <= 1'b0;
        maskIrq_q[i] <= 1'b0;
      end else begin
        event_q[i]   <= crossing[i];
        maskIrq_q[i] <= irqHit[i] && !ctrl_q[i].nmiSel;
      end
    end

    property p_det_set;
      crossing[i] |=> det_q[i];
    endproperty
    a_det_set: assert property (@(posedge ref_clk) disable iff (reset) p_det_set)
      else $error("detection flag missed a crossing");

    property p_event_pulse;
      crossing[i] |=> event_q[i] ##1 (event_q[i] == $past(crossing[i]));
    endproperty
    a_event_pulse: assert property (@(posedge ref_clk) disable iff (reset) p_event_pulse)
      else $error("event output does not follow crossing");

    property p_irq_edge;
      maskIrq_q[i] |-> !$past(ctrl_q[i].nmiSel)
        && (($past(evt[i].rise) && $past(ctrl_q[i].edgeSel) != EDGE_FALL)
            || ($past(evt[i].fall) && $past(ctrl_q[i].edgeSel) != EDGE_RISE));
    endproperty
    a_irq_edge: assert property (@(posedge ref_clk) disable iff (reset) p_irq_edge)
      else $error("maskable request without selected edge");

    property p_nmi_route;
      irqHit[i] && ctrl_q[i].nmiSel |=> nmiReq_q && !maskIrq_q[i];
    endproperty
    a_nmi_route: assert property (@(posedge ref_clk) disable iff (reset) p_nmi_route)
      else $error("non-maskable selection not routed");
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      nmiReq_q <= 1'b0;
    end else begin
      nmiReq_q <= (irqHit[0] && ctrl_q[0].nmiSel)
                  || (irqHit[1] && ctrl_q[1].nmiSel);
    end
  end

  assign levelSelectCh1 = ctrl_q[0].level;
  assign levelSelectCh2 = ctrl_q[1].level[2:0];
  assign cmpEnable1     = ctrl_q[0].enable;
  assign cmpEnable2     = ctrl_q[1].enable;
  assign vm1Reset       = vmReset_q[0];
  assign vm2Reset       = vmReset_q[1];
  assign nmiReq         = nmiReq_q;
  assign maskIrq1       = maskIrq_q[0];
  assign maskIrq2       = maskIrq_q[1];
  assign event1         = event_q[0];
  assign event2         = event_q[1];
  assign irq            = irq_q;

  property p_above_flag;
    rdFire && dphAddr_q == OFS_STAT1 && regAllowed(dphAddr_q, dphNonsec_q, secAttr_q)
      |=> hrdata_q[STAT_ABOVE] == $past(evt[0].level) && hreadyout_q;
  endproperty
  a_above_flag: assert property (@(posedge ref_clk) disable iff (reset) p_above_flag)
    else $error("status read does not show supply level");

  property p_lvl2_width;
    wrFire && dphAddr_q == OFS_CTRL2 && regAllowed(dphAddr_q, dphNonsec_q, secAttr_q)
      |=> ctrl_q[1].level == {2'h0, $past(hwdata[2:0])};
  endproperty
  a_lvl2_width: assert property (@(posedge ref_clk) disable iff (reset) p_lvl2_width)
    else $error("channel two level not the written three bits");

  property p_secure_block;
    wrFire && dphNonsec_q && secAttr_q[0] && dphAddr_q == OFS_CTRL1 |=> $stable(ctrl_q[0]);
  endproperty
  a_secure_block: assert property (@(posedge ref_clk) disable iff (reset) p_secure_block)
    else $error("non-secure write reached a secured register");

  property p_irq_level;
    (irqStat_q & irqMask_q) != 2'h0 |=> irq_q;
  endproperty
  a_irq_level: assert property (@(posedge ref_clk) disable iff (reset) p_irq_level)
    else $error("interrupt low with unmasked status set");
endmodule

// ===== testbench/svm_partner.sv
`timescale 1ns/1ns
module svm_partner #(
  parameter int THR_BASE = 2000,
  parameter int THR_STEP = 20,
  parameter int OSC_HALF = 4
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // supply in millivolts and threshold selects
  input  wire logic [15:0] supplyMv,
  input  wire logic [4:0]  levelSelectCh1,
  input  wire logic [2:0]  levelSelectCh2,
  // comparators and oscillator
  output logic             cmpAbove1,
  output logic             cmpAbove2,
  output logic             lowSpeedOsc
);
  logic [7:0] oscCnt_q;
  // comparators high while supply sits above the selected threshold
  assign cmpAbove1 = int'(supplyMv) > THR_BASE + THR_STEP * int'(levelSelectCh1);
  assign cmpAbove2 = int'(supplyMv) > THR_BASE + THR_STEP * int'(levelSelectCh2);
  // free-running slow oscillator
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      oscCnt_q    <= 8'h00;
      lowSpeedOsc <= 1'b0;
    end else if (oscCnt_q == 8'(OSC_HALF - 1)) begin
      oscCnt_q    <= 8'h00;
      lowSpeedOsc <= ~lowSpeedOsc;
    end else begin
      oscCnt_q <= oscCnt_q + 8'h01;
    end
  end
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ns
module tb;
  import svm_pkg::*;
  localparam int          OSC_HALF = 4;
  localparam int          LIMIT    = 20000;
  localparam logic [15:0] HI       = 16'h0BB8;
  localparam logic [15:0] LO       = 16'h03E8;
  logic        ref_clk, reset, hwrite, hnonsec, hreadyout, lowSpeedOsc;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, levelSelectCh2;
  logic [4:0]  levelSelectCh1;
  logic [15:0] supplyMv;
  logic        cmpAbove1, cmpAbove2, vm1Reset, vm2Reset, nmiReq, irq;
  logic        maskIrq1, maskIrq2, event1, event2, hresp, cmpEnable1, cmpEnable2;
  int          errors, testsRun, cyc;
  int          pulses[5];

  svm_partner #(.OSC_HALF(OSC_HALF)) farSide (
    .ref_clk(ref_clk), .reset(reset), .supplyMv(supplyMv),
    .levelSelectCh1(levelSelectCh1), .levelSelectCh2(levelSelectCh2),
    .cmpAbove1(cmpAbove1), .cmpAbove2(cmpAbove2), .lowSpeedOsc(lowSpeedOsc));

  supply_voltage_monitor_logic DUT (
    .ref_clk(ref_clk), .reset(reset), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hnonsec(hnonsec), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .lowSpeedOsc(lowSpeedOsc), .cmpAbove1(cmpAbove1), .cmpAbove2(cmpAbove2),
    .levelSelectCh1(levelSelectCh1), .levelSelectCh2(levelSelectCh2),
    .cmpEnable1(cmpEnable1), .cmpEnable2(cmpEnable2),
    .vm1Reset(vm1Reset), .vm2Reset(vm2Reset),
    .nmiReq(nmiReq), .maskIrq1(maskIrq1), .maskIrq2(maskIrq2),
    .event1(event1), .event2(event2), .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // pulse tallies: event1, event2, maskIrq1, maskIrq2, nmiReq
  always @(posedge ref_clk) begin
    pulses[0] += int'(event1 === 1'b1);
    pulses[1] += int'(event2 === 1'b1);
    pulses[2] += int'(maskIrq1 === 1'b1);
    pulses[3] += int'(maskIrq2 === 1'b1);
    pulses[4] += int'(nmiReq === 1'b1);
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      conclude();
    end
  end

  task automatic conclude();
    if (errors == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one single transfer: hold address phase until ready, then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     input logic ns, output logic [31:0] rd);
    haddr   <= {24'h000000, a};
    htrans  <= 2'h2;
    hwrite  <= w;
    hnonsec <= ns;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ns);
    logic [31:0] x;
    bus(a, 1'b1, d, ns, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic ns, input logic [31:0] m,
                     input logic [31:0] exp);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0000_0000, ns, x);
    chk(x & m, exp);
  endtask

  function automatic logic [31:0] mk(logic [1:0] e, logic n, logic r, logic f,
                                     logic [1:0] d, logic af);
    ch_ctrl_t c;
    c = '0;
    c.enable = 1'b1;
    c.edgeSel = e;
    c.nmiSel = n;
    c.resetAct = r;
    c.filterEn = f;
    c.divSel = d;
    c.restartAfterFall = af;
    return c;
  endfunction

  task automatic t_regs();
    logic [7:0] ofs[5] = '{OFS_CTRL1, OFS_CTRL2, OFS_IRQMASK, OFS_SEC, 8'h1C};
    foreach (ofs[i]) rdc(ofs[i], 1'b0, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(OFS_STAT1, 1'b0, 32'h0000_0003, 32'h0000_0001);
    wr(8'h1C, 32'hFFFF_FFFF, 1'b0);
    rdc(8'h1C, 1'b0, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(OFS_CTRL1, 32'hFFFF_FFFF, 1'b0);
    wr(OFS_CTRL2, 32'hFFFF_FFFF, 1'b0);
    rdc(OFS_CTRL1, 1'b0, 32'hFFFF_FFFF, CTRL1_WMASK);
    rdc(OFS_CTRL2, 1'b0, 32'hFFFF_FFFF, CTRL2_WMASK);
    chk(32'(levelSelectCh1), 32'h0000_001F);
    chk(32'(levelSelectCh2), 32'h0000_0007);
    chk({30'h0, cmpEnable2, cmpEnable1}, 32'h0000_0003);
    wr(OFS_CTRL1, 32'h0000_0000, 1'b0);
    wr(OFS_CTRL2, 32'h0000_0000, 1'b0);
    wt(1);
    chk({30'h0, cmpEnable2, cmpEnable1}, 32'h0000_0000);
  endtask

  task automatic t_edges();
    int b[5];
    for (int e = 0; e < 3; e++) begin
      b = pulses;
      wr(OFS_IRQMASK, 32'h0000_0001, 1'b0);
      wr(OFS_CTRL1, mk(2'(e), 1'b0, 1'b0, 1'b0, 2'h0, 1'b0), 1'b0);
      supplyMv <= LO;
      wt(8);
      rdc(OFS_STAT1, 1'b0, 32'h0000_0003, 32'h0000_0002);
      chk(32'(irq), 32'h0000_0001);
      rdc(OFS_IRQSTAT, 1'b0, 32'h0000_0001, 32'h0000_0001);
      wt(3);
      chk(32'(irq), 32'h0000_0000);
      wr(OFS_STAT1, 32'h0000_0000, 1'b0);
      rdc(OFS_STAT1, 1'b0, 32'h0000_0002, 32'h0000_0000);
      supplyMv <= HI;
      wt(8);
      rdc(OFS_STAT1, 1'b0, 32'h0000_0003, 32'h0000_0003);
      rdc(OFS_IRQSTAT, 1'b0, 32'h0000_0001, 32'h0000_0001);
      chk(32'(pulses[0] - b[0]), 32'h0000_0002);
      chk(32'(pulses[2] - b[2]), (e == 2) ? 32'h0000_0002 : 32'h0000_0001);
      chk(32'(pulses[4] - b[4]), 32'h0000_0000);
    end
  endtask

  task automatic t_ch2();
    int b[5];
    b = pulses;
    wr(OFS_IRQMASK, 32'h0000_0000, 1'b0);
    wr(OFS_CTRL1, mk(2'h2, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0), 1'b0);
    wr(OFS_CTRL2, mk(2'h2, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0) | 32'h3, 1'b0);
    wt(1);
    chk(32'(levelSelectCh2), 32'h0000_0003);
    supplyMv <= LO;
    wt(8);
    chk(32'(irq), 32'h0000_0000);
    rdc(OFS_STAT2, 1'b0, 32'h0000_0003, 32'h0000_0002);
    supplyMv <= HI;
    wt(8);
    rdc(OFS_IRQSTAT, 1'b0, 32'h0000_0003, 32'h0000_0003);
    chk(32'(pulses[4] - b[4]), 32'h0000_0002);
    chk(32'(pulses[2] - b[2]), 32'h0000_0000);
    chk(32'(pulses[1] - b[1]), 32'h0000_0002);
    chk(32'(pulses[3] - b[3]), 32'h0000_0002);
  endtask

  task automatic t_reset();
    int b[5];
    b = pulses;
    wr(OFS_CTRL1, mk(2'h2, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0), 1'b0);
    wr(OFS_CTRL2, mk(2'h2, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0), 1'b0);
    supplyMv <= LO;
    wt(600);
    chk(32'(vm1Reset), 32'h0000_0001);
    chk(32'(vm2Reset), 32'h0000_0001);
    supplyMv <= HI;
    wt(1900);
    chk(32'(vm1Reset), 32'h0000_0001);
    chk(32'(vm2Reset), 32'h0000_0001);
    wt(150);
    chk(32'(vm1Reset), 32'h0000_0000);
    chk(32'(vm2Reset), 32'h0000_0000);
    chk(32'(pulses[2] - b[2]), 32'h0000_0000);
    wr(OFS_CTRL2, 32'h0000_0000, 1'b0);
    wr(OFS_CTRL1, mk(2'h2, 1'b0, 1'b1, 1'b0, 2'h0, 1'b1), 1'b0);
    supplyMv <= LO;
    wt(6);
    chk(32'(vm1Reset), 32'h0000_0001);
    wt(2050);
    chk(32'(vm1Reset), 32'h0000_0000);
    supplyMv <= HI;
    wt(8);
  endtask

  task automatic t_filter();
    int b[5];
    int p;
    for (int d = 0; d < 4; d++) begin
      p = (2 << d) * 2 * OSC_HALF;
      wr(OFS_CTRL1, mk(2'h2, 1'b0, 1'b0, 1'b1, 2'(d), 1'b0), 1'b0);
      wt(2 * p + 16);
      b = pulses;
      supplyMv <= LO;
      wt(3);
      supplyMv <= HI;
      wt(2 * p + 16);
      chk(32'(pulses[0] - b[0]), 32'h0000_0000);
      supplyMv <= LO;
      wt(p - 8);
      chk(32'(pulses[0] - b[0]), 32'h0000_0000);
      wt(p + 32);
      chk(32'(pulses[0] - b[0]), 32'h0000_0001);
      supplyMv <= HI;
      wt(2 * p + 32);
      chk(32'(pulses[0] - b[0]), 32'h0000_0002);
    end
    wr(OFS_CTRL1, 32'h0000_0000, 1'b0);
  endtask

  task automatic t_sec();
    wr(OFS_SEC, 32'h0000_0001, 1'b0);
    wr(OFS_CTRL1, 32'h0000_0105, 1'b0);
    wr(OFS_CTRL1, 32'h0000_001F, 1'b1);
    rdc(OFS_CTRL1, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(OFS_CTRL1, 1'b0, 32'hFFFF_FFFF, 32'h0000_0105);
    chk(32'(levelSelectCh1), 32'h0000_0005);
    wr(OFS_SEC, 32'h0000_0000, 1'b1);
    rdc(OFS_SEC, 1'b0, 32'h0000_0003, 32'h0000_0001);
    wr(OFS_CTRL2, 32'h0000_0002, 1'b1);
    rdc(OFS_CTRL2, 1'b1, 32'hFFFF_FFFF, 32'h0000_0002);
    wr(OFS_SEC, 32'h0000_0002, 1'b0);
    rdc(OFS_STAT2, 1'b1, 32'h0000_0003, 32'h0000_0000);
    rdc(OFS_STAT2, 1'b0, 32'h0000_0003, 32'h0000_0001);
    chk(32'(hresp), 32'h0000_0000);
    wr(OFS_SEC, 32'h0000_0000, 1'b0);
    wr(OFS_CTRL1, 32'h0000_0000, 1'b0);
    wr(OFS_CTRL2, 32'h0000_0000, 1'b0);
  endtask

  initial begin
    reset = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    hnonsec = 1'b0;
    supplyMv = HI;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_sec();
    t_edges();
    t_ch2();
    t_reset();
    t_filter();
    conclude();
  end
endmodule
